/* design/drive_cfg_pkg.sv */
package drive_cfg_pkg;

	// Clock and timing
	localparam int CLK_HZ = 20000000;
	localparam int ENABLE_BLINK_MS = 1500;
	localparam int ENABLE_BLINK_CYC = CLK_HZ / 1000 * ENABLE_BLINK_MS;
	localparam int PULSE_ON_MS = 200;
	localparam int PULSE_ON_CYC = CLK_HZ / 1000 * PULSE_ON_MS;
	localparam int PULSE_GAP_MS = 300;
	localparam int PULSE_GAP_CYC = CLK_HZ / 1000 * PULSE_GAP_MS;
	localparam int DIGIT_PAUSE_MS = 1500;
	localparam int DIGIT_PAUSE_CYC = CLK_HZ / 1000 * DIGIT_PAUSE_MS;
	localparam int CODE_PAUSE_MS = 3000;
	localparam int CODE_PAUSE_CYC = CLK_HZ / 1000 * CODE_PAUSE_MS;
	localparam int TICK_US = 1000;
	localparam int TICK_CYC = CLK_HZ / 1000000 * TICK_US;
	localparam int SYNC_FILL_CYC = 2;

	// Switch bank fields
	localparam int SW_ADDR_LSB = 0;
	localparam int SW_ADDR_W = 4;
	localparam int SW_BAUD_BIT = 4;
	localparam int SW_BRIDGE_BIT = 6;
	localparam int SW_TERM_BIT = 7;

	// AHB register offsets
	localparam logic [7:0] REG_CONFIG = 8'h00;
	localparam logic [7:0] REG_MODE_PARAM = 8'h04;
	localparam logic [7:0] REG_BAUD_NEW = 8'h08;
	localparam logic [7:0] REG_FAULT = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_IRQ_STATUS = 8'h14;
	localparam logic [7:0] REG_IRQ_MASK = 8'h18;
	localparam logic [7:0] REG_BAUD_ACTIVE = 8'h1C;

	// Reset values
	localparam logic [7:0] MODE_PARAM_RST = 8'h01;
	localparam logic [3:0] BAUD_CODE_RST = 4'h0;

	// Baud codes, code 0 is 1 Mbit/s
	localparam logic [3:0] BAUD_1M = 4'h0;

	// Mode-of-operation parameter encodings
	localparam logic [7:0] MOP_PROFILE_POS = 8'h01;
	localparam logic [7:0] MOP_PROFILE_VEL = 8'h03;
	localparam logic [7:0] MOP_HOMING = 8'h06;
	localparam logic [7:0] MOP_INTERP = 8'h07;
	localparam logic [7:0] MOP_ANALOG_VEL = 8'hFE;
	localparam logic [7:0] MOP_LIMIT_AWAY = 8'hFD;

	// Interrupt bit positions
	localparam int IRQ_W = 3;
	localparam int IRQ_FAULT = 0;
	localparam int IRQ_ENABLE_LOST = 1;
	localparam int IRQ_MODE_CHANGE = 2;

	typedef enum logic [2:0]
	{
		MODE_NONE = 3'h0,
		MODE_PROFILE_POS = 3'h1,
		MODE_PROFILE_VEL = 3'h2,
		MODE_HOMING = 3'h3,
		MODE_INTERP = 3'h4,
		MODE_ANALOG_VEL = 3'h5,
		MODE_LIMIT_AWAY = 3'h6
	} op_mode_t;

	typedef struct packed
	{
		logic [3:0] node_addr;
		logic baud_sel;
		logic bridge;
		logic term;
	} switch_cfg_t;

	typedef struct packed
	{
		logic led_first;
		logic led_second;
	} led_pair_t;

	typedef struct packed
	{
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic hsel;
		logic [31:0] hwdata;
		logic hready;
	} ahb_req_t;

	typedef struct packed
	{
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
	} ahb_rsp_t;

	// Maps the mode parameter to an operating mode
	function automatic op_mode_t decode_mode(input logic [7:0] p);
		op_mode_t m;
		m = MODE_NONE;
		case (p)
			MOP_PROFILE_POS: m = MODE_PROFILE_POS;
			MOP_PROFILE_VEL: m = MODE_PROFILE_VEL;
			MOP_HOMING: m = MODE_HOMING;
			MOP_INTERP: m = MODE_INTERP;
			MOP_ANALOG_VEL: m = MODE_ANALOG_VEL;
			MOP_LIMIT_AWAY: m = MODE_LIMIT_AWAY;
			default: m = MODE_NONE;
		endcase
		return m;
	endfunction : decode_mode

endpackage : drive_cfg_pkg

/* design/sync_two_ff.sv */
`timescale 1ns/100ps
`default_nettype none
module sync_two_ff
	import drive_cfg_pkg::*;
#(
	parameter int W = 1
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Data
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	typedef struct packed
	{
		logic [W-1:0] first;
		logic [W-1:0] second;
	} sync_state_t;

	sync_state_t st_q;
	sync_state_t st_d;

	// Two stages, first read only by the second
	always_comb
	begin
		st_d = st_q;
		st_d.first = async_in;
		st_d.second = st_q.first;
	end

	always_ff @(posedge mclk)
	begin
		if (!resetn)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign sync_out = st_q.second;

endmodule : sync_two_ff
`default_nettype wire

/* design/blink_coder.sv */
`timescale 1ns/100ps
`default_nettype none
module blink_coder
	import drive_cfg_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Control
	input wire logic fault_active,
	input wire logic [3:0] digit_first,
	input wire logic [3:0] digit_second,
	input wire logic enable_missing,
	// LEDs
	output led_pair_t leds
);

	typedef enum logic [2:0]
	{
		BL_IDLE = 3'b000,
		BL_D1_ON = 3'b001,
		BL_D1_GAP = 3'b011,
		BL_D2_ON = 3'b010,
		BL_D2_GAP = 3'b110,
		BL_PAUSE = 3'b111,
		BL_EN_ON = 3'b101,
		BL_EN_OFF = 3'b100
	} blink_state_t;

	typedef struct packed
	{
		blink_state_t state;
		logic [31:0] timer;
		logic [3:0] pulses;
		led_pair_t leds;
	} blink_reg_t;

	blink_reg_t st_q;
	blink_reg_t st_d;

	localparam logic [31:0] ON_CYC = 32'(PULSE_ON_CYC);
	localparam logic [31:0] GAP_CYC = 32'(PULSE_GAP_CYC);
	localparam logic [31:0] DPAUSE_CYC = 32'(DIGIT_PAUSE_CYC);
	localparam logic [31:0] CPAUSE_CYC = 32'(CODE_PAUSE_CYC);
	localparam logic [31:0] EN_PERIOD_CYC = 32'(ENABLE_BLINK_CYC);

	// Pulse sequencer for fault code and missing-enable blink
	always_comb
	begin
		st_d = st_q;
		if (st_q.timer != 32'h0)
			st_d.timer = st_q.timer - 32'h1;
		case (st_q.state)
			BL_IDLE:
			begin
				st_d.leds = '0;
				if (fault_active && digit_first != 4'h0)
				begin
					st_d.state = BL_D1_ON;
					st_d.pulses = digit_first;
					st_d.timer = ON_CYC;
				end
				else if (fault_active)
				begin
					st_d.state = BL_PAUSE;
					st_d.timer = DPAUSE_CYC;
				end
				else if (enable_missing)
				begin
					st_d.state = BL_EN_ON;
					st_d.timer = ON_CYC;
				end
			end
			BL_D1_ON:
			begin
				st_d.leds = '{led_first: 1'b1, led_second: 1'b1};
				if (st_q.timer == 32'h0)
				begin
					st_d.leds = '0;
					st_d.pulses = st_q.pulses - 4'h1;
					st_d.state = BL_D1_GAP;
					st_d.timer = (st_q.pulses == 4'h1) ? DPAUSE_CYC : GAP_CYC;
				end
			end
			BL_D1_GAP:
			begin
				if (st_q.timer == 32'h0)
				begin
					if (st_q.pulses != 4'h0)
					begin
						st_d.state = BL_D1_ON;
						st_d.timer = ON_CYC;
					end
					else if (digit_second != 4'h0)
					begin
						st_d.state = BL_D2_ON;
						st_d.pulses = digit_second;
						st_d.timer = ON_CYC;
					end
					else
					begin
						st_d.state = BL_PAUSE;
						st_d.timer = CPAUSE_CYC;
					end
				end
			end
			BL_D2_ON:
			begin
				st_d.leds = '{led_first: 1'b0, led_second: 1'b1};
				if (st_q.timer == 32'h0)
				begin
					st_d.leds = '0;
					st_d.pulses = st_q.pulses - 4'h1;
					st_d.state = BL_D2_GAP;
					st_d.timer = GAP_CYC;
				end
			end
			BL_D2_GAP:
			begin
				if (st_q.timer == 32'h0)
				begin
					if (st_q.pulses != 4'h0)
					begin
						st_d.state = BL_D2_ON;
						st_d.timer = ON_CYC;
					end
					else
					begin
						st_d.state = BL_PAUSE;
						st_d.timer = CPAUSE_CYC;
					end
				end
			end
			BL_PAUSE:
			begin
				st_d.leds = '0;
				if (st_q.timer == 32'h0)
					st_d.state = BL_IDLE;
			end
			BL_EN_ON:
			begin
				st_d.leds = '{led_first: 1'b1, led_second: 1'b1};
				if (fault_active)
				begin
					st_d.leds = '0;
					st_d.state = BL_IDLE;
				end
				else if (st_q.timer == 32'h0)
				begin
					st_d.leds = '0;
					st_d.state = BL_EN_OFF;
					st_d.timer = EN_PERIOD_CYC - ON_CYC;
				end
			end
			BL_EN_OFF:
			begin
				st_d.leds = '0;
				if (fault_active || st_q.timer == 32'h0)
					st_d.state = BL_IDLE;
			end
			default:
			begin
				st_d.state = BL_IDLE;
				st_d.leds = '0;
			end
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (!resetn)
			st_q <= '{state: BL_IDLE, timer: 32'h0, pulses: 4'h0, leds: '0};
		else
			st_q <= st_d;
	end

	assign leds = st_q.leds;

endmodule : blink_coder
`default_nettype wire

/* design/drive_config_and_status_blink.sv */
// The register addresses and register access over AHB-Lite were decided locally.
`timescale 1ns/100ps
`default_nettype none
module drive_config_and_status_blink
	import drive_cfg_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// AHB-Lite slave
	input wire ahb_req_t ahb_req,
	output ahb_rsp_t ahb_rsp,
	// Switch bank and pins
	input wire logic [7:0] config_switches,
	input wire logic enable_in,
	input wire logic limit_chain_in,
	output logic limit_chain_out,
	// Drive-side status
	input wire logic fault_active,
	input wire logic [7:0] fault_code,
	input wire logic net_state_enabled,
	input wire logic high_speed_submode,
	// Configuration results
	output logic [3:0] node_address,
	output logic can_enabled,
	output logic baud_sel,
	output logic [3:0] can_baud_code,
	output logic bus_termination_switch,
	output op_mode_t op_mode,
	output logic network_mode,
	output logic drive_enabled,
	// Indication
	output logic status_led_first,
	output logic status_led_second,
	output logic irq
);

	typedef struct packed
	{
		logic captured;
		logic [1:0] fill;
		switch_cfg_t sw;
		logic [7:0] mode_param;
		logic [3:0] baud_new;
		logic [3:0] baud_active;
		op_mode_t mode;
		logic drive_en;
		logic chain_out;
		logic [IRQ_W-1:0] irq_status;
		logic [IRQ_W-1:0] irq_mask;
		logic fault_prev;
		logic enable_prev;
		logic ph_valid;
		logic ph_write;
		logic [7:0] ph_addr;
		logic [31:0] rdata;
	} top_state_t;

	localparam logic [1:0] SYNC_FILL = 2'(SYNC_FILL_CYC);

	// Power-on state, baud object at the 1 Mbit/s code
	localparam top_state_t ST_POWER_ON = '{captured: 1'b0, fill: 2'h0, sw: '0, mode_param: MODE_PARAM_RST,
		baud_new: BAUD_1M, baud_active: BAUD_CODE_RST, mode: MODE_NONE, drive_en: 1'b0, chain_out: 1'b0,
		irq_status: '0, irq_mask: '0, fault_prev: 1'b0, enable_prev: 1'b0, ph_valid: 1'b0,
		ph_write: 1'b0, ph_addr: 8'h00, rdata: 32'h0};

	top_state_t st_q = ST_POWER_ON;
	top_state_t st_d;

	logic [7:0] sw_sync;
	logic [1:0] pin_sync;
	led_pair_t leds;
	logic enable_s;
	logic chain_s;
	logic [IRQ_W-1:0] irq_events;

	// Pins from outside pass two flops
	sync_two_ff #(.W(8)) u_sw_sync
	(
		.mclk(mclk),
		.resetn(resetn),
		.async_in(config_switches),
		.sync_out(sw_sync)
	);

	sync_two_ff #(.W(2)) u_pin_sync
	(
		.mclk(mclk),
		.resetn(resetn),
		.async_in({enable_in, limit_chain_in}),
		.sync_out(pin_sync)
	);

	assign enable_s = pin_sync[1];
	assign chain_s = pin_sync[0];

	// Blink code generator
	blink_coder u_blink
	(
		.mclk(mclk),
		.resetn(resetn),
		.fault_active(fault_active),
		.digit_first(fault_code[7:4]),
		.digit_second(fault_code[3:0]),
		.enable_missing(!enable_s && st_q.captured),
		.leds(leds)
	);

	// Read mux for register offsets
	function automatic logic [31:0] read_reg(input top_state_t s, input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0;
		case (a)
			REG_CONFIG: v = {24'h0, s.sw.term, 1'b0, s.sw.bridge, s.sw.baud_sel, s.sw.node_addr};
			REG_MODE_PARAM: v = {24'h0, s.mode_param};
			REG_BAUD_NEW: v = {28'h0, s.baud_new};
			REG_FAULT: v = {24'h0, fault_code};
			REG_STATUS: v = {25'h0, s.drive_en, enable_s, s.captured, 1'b0, s.mode};
			REG_IRQ_STATUS: v = {{(32-IRQ_W){1'b0}}, s.irq_status};
			REG_IRQ_MASK: v = {{(32-IRQ_W){1'b0}}, s.irq_mask};
			REG_BAUD_ACTIVE: v = {28'h0, s.baud_active};
			default: v = 32'h0;
		endcase
		return v;
	endfunction : read_reg

	// Mode choice from address and parameter
	function automatic op_mode_t pick_mode(input logic [3:0] addr, input logic [7:0] p);
		op_mode_t m;
		m = MODE_ANALOG_VEL;
		if (addr != 4'h0)
			m = decode_mode(p);
		return m;
	endfunction : pick_mode

	// All block state in one next-value process
	always_comb
	begin
		st_d = st_q;
		st_d.rdata = 32'h0;
		// Capture switches once, first cycle after sync fill
		if (!st_q.captured && st_q.fill != SYNC_FILL)
			st_d.fill = st_q.fill + 2'h1;
		else if (!st_q.captured)
		begin
			st_d.captured = 1'b1;
			st_d.sw.node_addr = sw_sync[SW_ADDR_LSB +: SW_ADDR_W];
			st_d.sw.baud_sel = sw_sync[SW_BAUD_BIT];
			st_d.sw.bridge = sw_sync[SW_BRIDGE_BIT];
			st_d.sw.term = sw_sync[SW_TERM_BIT];
		end
		// Mode selection follows the parameter, except analogue velocity at address zero
		st_d.mode = st_q.captured ? pick_mode(st_q.sw.node_addr, st_q.mode_param) : MODE_NONE;
		// Drive enable source depends on mode group
		if (st_q.mode == MODE_NONE)
			st_d.drive_en = 1'b0;
		else if (st_q.sw.node_addr != 4'h0 && st_q.mode != MODE_ANALOG_VEL)
			st_d.drive_en = net_state_enabled && enable_s;
		else
			st_d.drive_en = enable_s;
		// Limit chain bridge
		st_d.chain_out = st_q.sw.bridge && st_q.captured ? chain_s : 1'b0;
		// Data phase of a write
		if (st_q.ph_valid && st_q.ph_write)
		begin
			case (st_q.ph_addr)
				REG_MODE_PARAM: st_d.mode_param = ahb_req.hwdata[7:0];
				REG_BAUD_NEW: st_d.baud_new = ahb_req.hwdata[3:0];
				REG_IRQ_MASK: st_d.irq_mask = ahb_req.hwdata[IRQ_W-1:0];
				REG_IRQ_STATUS: st_d.irq_status = st_q.irq_status & ~ahb_req.hwdata[IRQ_W-1:0];
				default: st_d.irq_mask = st_d.irq_mask;
			endcase
		end
		// Events set after the clear so set wins
		st_d.irq_status = st_d.irq_status | irq_events;
		st_d.fault_prev = fault_active;
		st_d.enable_prev = enable_s;
		// Address phase capture
		st_d.ph_valid = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
		st_d.ph_write = ahb_req.hwrite;
		st_d.ph_addr = ahb_req.haddr[7:0];
		if (ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1] && !ahb_req.hwrite)
			st_d.rdata = read_reg(st_q, ahb_req.haddr[7:0]);
	end

	// Fault rise, enable loss, mode change
	always_comb
	begin
		irq_events = '0;
		irq_events[IRQ_FAULT] = fault_active && !st_q.fault_prev;
		irq_events[IRQ_ENABLE_LOST] = st_q.enable_prev && !enable_s;
		irq_events[IRQ_MODE_CHANGE] = st_q.captured && (pick_mode(st_q.sw.node_addr, st_q.mode_param) != st_q.mode);
	end

	// Baud code survives reset, so only a reset applies a new one
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			st_q <= '{captured: 1'b0, fill: 2'h0, sw: '0, mode_param: MODE_PARAM_RST, baud_new: st_q.baud_new,
				baud_active: st_q.baud_new, mode: MODE_NONE, drive_en: 1'b0, chain_out: 1'b0,
				irq_status: '0, irq_mask: '0, fault_prev: 1'b0, enable_prev: 1'b0, ph_valid: 1'b0,
				ph_write: 1'b0, ph_addr: 8'h00, rdata: 32'h0};
		end
		else
			st_q <= st_d;
	end

	// Outputs
	assign ahb_rsp.hrdata = st_q.rdata;
	assign ahb_rsp.hreadyout = 1'b1;
	assign ahb_rsp.hresp = 1'b0;
	assign node_address = st_q.sw.node_addr;
	assign can_enabled = st_q.captured && (st_q.sw.node_addr != 4'h0);
	assign baud_sel = st_q.sw.baud_sel;
	assign can_baud_code = high_speed_submode ? st_q.baud_active : {3'h0, st_q.sw.baud_sel};
	assign bus_termination_switch = st_q.sw.term;
	assign op_mode = st_q.mode;
	assign network_mode = st_q.captured && st_q.sw.node_addr != 4'h0 && st_q.mode != MODE_ANALOG_VEL;
	assign drive_enabled = st_q.drive_en;
	assign limit_chain_out = st_q.chain_out;
	assign status_led_first = leds.led_first;
	assign status_led_second = leds.led_second;
	assign irq = |(st_q.irq_status & ~st_q.irq_mask); // Set mask bits silence their event

endmodule : drive_config_and_status_blink
`default_nettype wire

/* test/drive_cfg_blink_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module drive_cfg_blink_assertions
	import drive_cfg_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Watched ports
	input wire ahb_rsp_t ahb_rsp,
	input wire logic [7:0] config_switches,
	input wire logic enable_in,
	input wire logic limit_chain_in,
	input wire logic limit_chain_out,
	input wire logic net_state_enabled,
	input wire logic high_speed_submode,
	input wire logic [3:0] node_address,
	input wire logic can_enabled,
	input wire logic baud_sel,
	input wire logic [3:0] can_baud_code,
	input wire op_mode_t op_mode,
	input wire logic network_mode,
	input wire logic drive_enabled,
	input wire logic status_led_first,
	input wire logic status_led_second,
	input wire logic irq
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	// Bus never stalls and never errors
	property p_bus_okay;
		ahb_rsp.hreadyout && !ahb_rsp.hresp;
	endproperty
	a_bus_okay: assert property (p_bus_okay)
		else $error("bus answer not ready or not okay");

	// Switches seen a few edges after release
	property p_capture;
		$rose(resetn) ##0 $stable(config_switches)[*5] |-> node_address == config_switches[3:0]
			&& baud_sel == config_switches[4];
	endproperty
	a_capture: assert property (p_capture)
		else $error("switch bank not captured after reset");

	// Settings frozen once running
	property p_hold;
		op_mode != MODE_NONE |=> $stable(node_address) && $stable(baud_sel);
	endproperty
	a_hold: assert property (p_hold)
		else $error("captured settings changed while running");

	// Network access only with a nonzero address
	property p_can_en;
		can_enabled == (node_address != 4'h0);
	endproperty
	a_can_en: assert property (p_can_en)
		else $error("network access does not match node address");

	// Address zero forces analogue velocity mode
	property p_addr0_mode;
		node_address == 4'h0 && op_mode != MODE_NONE |-> op_mode == MODE_ANALOG_VEL;
	endproperty
	a_addr0_mode: assert property (p_addr0_mode)
		else $error("address zero without analogue mode");

	// Switch rate unless high speed submode
	property p_baud;
		$stable(high_speed_submode) && !high_speed_submode && op_mode != MODE_NONE
			|-> can_baud_code == {3'h0, baud_sel};
	endproperty
	a_baud: assert property (p_baud)
		else $error("link rate not from baud switch");

	// Chain output only follows the input
	property p_bridge;
		$rose(limit_chain_out) |-> $past(limit_chain_in, 2) || $past(limit_chain_in, 3)
			|| $past(limit_chain_in, 4);
	endproperty
	a_bridge: assert property (p_bridge)
		else $error("chain output rose without chain input");

	// Missing enable pin always disables
	property p_pin_off;
		(!enable_in)[*5] |-> !drive_enabled;
	endproperty
	a_pin_off: assert property (p_pin_off)
		else $error("drive enabled without enable pin");

	// Network modes obey the network state
	property p_net_off;
		(network_mode && !net_state_enabled)[*3] |-> !drive_enabled;
	endproperty
	a_net_off: assert property (p_net_off)
		else $error("drive enabled against network state");

	// First LED never lights alone
	property p_led_pair;
		status_led_first |-> status_led_second;
	endproperty
	a_led_pair: assert property (p_led_pair)
		else $error("first status LED lit alone");

	// Main scenarios
	c_irq: cover property (irq);
	c_bridge: cover property ($rose(limit_chain_out));
	c_addr0: cover property (op_mode == MODE_ANALOG_VEL && !can_enabled);
endmodule : drive_cfg_blink_assertions

bind drive_config_and_status_blink drive_cfg_blink_assertions i_drive_cfg_blink_assertions (.mclk(mclk),
	.resetn(resetn), .ahb_rsp(ahb_rsp), .config_switches(config_switches), .enable_in(enable_in),
	.limit_chain_in(limit_chain_in), .limit_chain_out(limit_chain_out), .net_state_enabled(net_state_enabled),
	.high_speed_submode(high_speed_submode), .node_address(node_address), .can_enabled(can_enabled),
	.baud_sel(baud_sel), .can_baud_code(can_baud_code), .op_mode(op_mode), .network_mode(network_mode),
	.drive_enabled(drive_enabled), .status_led_first(status_led_first),
	.status_led_second(status_led_second), .irq(irq));
`default_nettype wire

/* test/switch_panel_model.sv */
`timescale 1ns/100ps
`default_nettype none
module switch_panel_model
(
	// Clock
	input wire logic mclk,
	// Settings from the bench
	input wire logic [7:0] sw_want,
	input wire logic en_want,
	input wire logic chain_want,
	// Contacts towards the drive
	output logic [7:0] config_switches,
	output logic enable_in,
	output logic limit_chain_in
);
	logic [9:0] pins_q = 10'h000;

	// Contacts move just after an edge, never on it
	always @(posedge mclk)
		pins_q <= {sw_want, en_want, chain_want};

	// Static contacts always show a defined level
	assign config_switches = pins_q[9:2];
	assign enable_in = pins_q[1];
	assign limit_chain_in = pins_q[0];
endmodule : switch_panel_model
`default_nettype wire

/* test/drive_config_and_status_blink_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module drive_config_and_status_blink_tb_top
	import drive_cfg_pkg::*;
;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [7:0] sw_want = 8'hD5;
	logic en_want = 1'b0;
	logic chain_want = 1'b0;
	logic fault_active = 1'b0;
	logic [7:0] fault_code = 8'h21;
	logic net_state_enabled = 1'b0;
	logic high_speed_submode = 1'b0;
	logic [31:0] rdata;
	int err_count = 0;
	int check_count = 0;
	ahb_req_t ahb_req;
	ahb_rsp_t ahb_rsp;
	logic [7:0] config_switches;
	logic enable_in, limit_chain_in, limit_chain_out, can_enabled, baud_sel, term, network_mode;
	logic drive_enabled, led_first, led_second, irq;
	logic [3:0] node_address, can_baud_code;
	op_mode_t op_mode;
	logic [7:0] mode_par [7] = '{MOP_PROFILE_POS, MOP_PROFILE_VEL, MOP_HOMING, MOP_INTERP, MOP_ANALOG_VEL,
		MOP_LIMIT_AWAY, 8'h55};
	op_mode_t mode_exp [7] = '{MODE_PROFILE_POS, MODE_PROFILE_VEL, MODE_HOMING, MODE_INTERP,
		MODE_ANALOG_VEL, MODE_LIMIT_AWAY, MODE_NONE};

	// Single slave, so its ready is the bus ready
	assign ahb_req = '{haddr: haddr, htrans: htrans, hwrite: hwrite, hsize: 3'h2, hsel: 1'b1,
		hwdata: hwdata, hready: ahb_rsp.hreadyout};

	always #25 mclk = ~mclk;

	drive_config_and_status_blink i_drive_config_and_status_blink (.mclk(mclk), .resetn(resetn),
		.ahb_req(ahb_req), .ahb_rsp(ahb_rsp), .config_switches(config_switches), .enable_in(enable_in),
		.limit_chain_in(limit_chain_in), .limit_chain_out(limit_chain_out), .fault_active(fault_active),
		.fault_code(fault_code), .net_state_enabled(net_state_enabled), .high_speed_submode(high_speed_submode),
		.node_address(node_address), .can_enabled(can_enabled), .baud_sel(baud_sel),
		.can_baud_code(can_baud_code), .bus_termination_switch(term), .op_mode(op_mode),
		.network_mode(network_mode), .drive_enabled(drive_enabled), .status_led_first(led_first),
		.status_led_second(led_second), .irq(irq));

	switch_panel_model i_switch_panel_model (.mclk(mclk), .sw_want(sw_want), .en_want(en_want),
		.chain_want(chain_want), .config_switches(config_switches), .enable_in(enable_in),
		.limit_chain_in(limit_chain_in));

	task automatic print_verdict();
		if (err_count == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask : cyc

	// One single transfer, address phase then data phase
	task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
		@(posedge mclk);
		haddr <= {24'h0, addr};
		hwrite <= wr;
		htrans <= 2'h2;
		do
			@(posedge mclk);
		while (ahb_rsp.hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wdata;
		do
			@(posedge mclk);
		while (ahb_rsp.hreadyout !== 1'b1);
		rdata = ahb_rsp.hrdata;
	endtask : bus

	task automatic rd(input logic [7:0] addr, input logic [31:0] exp, input string name);
		bus(1'b0, addr, 32'h0);
		check(name, rdata, exp);
	endtask : rd

	task automatic do_reset();
		resetn <= 1'b0;
		cyc(10);
		resetn <= 1'b1;
		cyc(6);
	endtask : do_reset

	// Main sequence
	initial
	begin
		do_reset();
		check("node_address", 32'(node_address), 32'h5);
		check("can_enabled", 32'(can_enabled), 32'h1);
		check("baud_sel", 32'(baud_sel), 32'h1);
		check("term", 32'(term), 32'h1);
		check("can_baud", 32'(can_baud_code), 32'h1);
		check("op_mode_rst", 32'(op_mode), 32'(MODE_PROFILE_POS));
		check("led_first_en", 32'(led_first), 32'h1);
		check("led_second_en", 32'(led_second), 32'h1);
		high_speed_submode <= 1'b1;
		rd(REG_BAUD_ACTIVE, 32'(BAUD_1M), "baud_active");
		check("can_baud_hs", 32'(can_baud_code), 32'(BAUD_1M));
		sw_want <= 8'h00;
		cyc(8);
		check("node_hold", 32'(node_address), 32'h5);
		check("baud_hold", 32'(baud_sel), 32'h1);
		chain_want <= 1'b1;
		cyc(6);
		check("chain_on", 32'(limit_chain_out), 32'h1);
		chain_want <= 1'b0;
		cyc(6);
		check("chain_off", 32'(limit_chain_out), 32'h0);
		for (int i = 0; i < 7; i++)
		begin
			bus(1'b1, REG_MODE_PARAM, 32'(mode_par[i]));
			rd(REG_MODE_PARAM, 32'(mode_par[i]), "mode_param");
			cyc(3);
			check("op_mode", 32'(op_mode), 32'(mode_exp[i]));
			if (i < 6)
				check("network_mode", 32'(network_mode), 32'(mode_exp[i] != MODE_ANALOG_VEL));
		end
		// Enable pin in analogue mode, then network mode
		bus(1'b1, REG_MODE_PARAM, 32'(MOP_ANALOG_VEL));
		en_want <= 1'b1;
		cyc(6);
		check("drive_en_pin", 32'(drive_enabled), 32'h1);
		bus(1'b1, REG_MODE_PARAM, 32'(MOP_PROFILE_POS));
		cyc(6);
		check("drive_en_net0", 32'(drive_enabled), 32'h0);
		net_state_enabled <= 1'b1;
		cyc(4);
		check("drive_en_net1", 32'(drive_enabled), 32'h1);
		// Interrupt raised, masked and cleared
		bus(1'b1, REG_IRQ_MASK, 32'h6);
		bus(1'b1, REG_IRQ_STATUS, 32'h7);
		fault_active <= 1'b1;
		cyc(3);
		bus(1'b0, REG_IRQ_STATUS, 32'h0);
		check("irq_fault_bit", rdata & 32'h1, 32'h1);
		check("irq_on", 32'(irq), 32'h1);
		check("led_first_fault", 32'(led_first), 32'h1);
		check("led_second_fault", 32'(led_second), 32'h1);
		bus(1'b1, REG_IRQ_MASK, 32'h7);
		cyc(2);
		check("irq_masked", 32'(irq), 32'h0);
		bus(1'b1, REG_IRQ_STATUS, 32'h1);
		bus(1'b0, REG_IRQ_STATUS, 32'h0);
		check("irq_cleared", rdata & 32'h1, 32'h0);
		// Unmapped and read-only places
		bus(1'b1, 8'h20, 32'hFFFFFFFF);
		rd(8'h20, 32'h0, "unmapped");
		bus(1'b1, REG_BAUD_ACTIVE, 32'h5);
		rd(REG_BAUD_ACTIVE, 32'h0, "baud_ro");
		// New rate waits for the next reset
		bus(1'b1, REG_BAUD_NEW, 32'h3);
		rd(REG_BAUD_ACTIVE, 32'h0, "baud_wait");
		check("can_baud_wait", 32'(can_baud_code), 32'h0);
		fault_active <= 1'b0;
		do_reset();
		rd(REG_BAUD_ACTIVE, 32'h3, "baud_applied");
		check("can_baud_new", 32'(can_baud_code), 32'h3);
		check("addr0_can", 32'(can_enabled), 32'h0);
		check("addr0_mode", 32'(op_mode), 32'(MODE_ANALOG_VEL));
		check("led_idle", 32'({led_first, led_second}), 32'h0);
		bus(1'b1, REG_MODE_PARAM, 32'(MOP_HOMING));
		cyc(3);
		check("addr0_param", 32'(op_mode), 32'(MODE_ANALOG_VEL));
		print_verdict();
	end

	// Cuts a hung run short
	initial
	begin
		cyc(5000);
		err_count++;
		print_verdict();
	end
endmodule : drive_config_and_status_blink_tb_top
`default_nettype wire
